/* File: core/fticu_map.vh */
// Constants for the float-to-integer conversion unit: offsets, opcodes, modes, reset values
//
// Overview of operation
// RULE_01: Each conversion takes two cycles; result lands after one further issue slot.
// RULE_02: The instruction in the delay slot must not read or write the destination.
// RULE_03: Conversions never change any of the seven floating-point status flags.
// RULE_04: Source and destination select one of eight registers; source above destination.
// RULE_05: Signed 16-bit conversion rounds to nearest, ties to even, into the low half.
// RULE_06: Signed 16-bit results fill the upper half with copies of bit 15.
// RULE_07: Signed 32-bit conversion decoded by first word e688, second word upper ten zero.
// RULE_08: Signed 32-bit conversion truncates toward zero, full two's-complement result.
// RULE_09: Unsigned 16-bit truncating conversion decoded by e68e with second word bit 15 clear.
// RULE_10: Same first word with second word bit 15 set selects unsigned 16-bit rounding.
// RULE_11: Unsigned 16-bit truncation writes low half and clears the upper half.
// RULE_12: Unsigned 16-bit rounding rounds to nearest, ties even, clears upper half.
// RULE_13: Unsigned 16-bit conversions saturate large positive inputs to 65535.
// RULE_14: Unsigned 16-bit conversions give zero for negative inputs.
// RULE_15: Unsigned 32-bit conversion decoded by first word e68a, second word upper ten zero.
// RULE_16: Unsigned 32-bit conversion truncates positive inputs toward zero.
// RULE_17: Unsigned 32-bit conversion gives all zeros for negative inputs.
// RULE_18: Signed conversions saturate out-of-range inputs to the most positive or negative value.
// RULE_19: A new conversion may be issued every cycle, each finishing two cycles later.
`ifndef FTICU_MAP_VH
`define FTICU_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FTICU_OFF_FREG_BASE 8'h00
`define FTICU_OFF_STATUS 8'h20
`define FTICU_OFF_ISSUE 8'h24
`define FTICU_OFF_INFO 8'h28

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define FTICU_STATUS_BITS 7
`define FTICU_STATUS_RESET 7'h00
`define FTICU_INFO_REJECT_BIT 16
`define FTICU_INFO_BUSY_BIT 17

// ----------------------------------------------------------------
// Opcode first words and second-word fields
// ----------------------------------------------------------------
`define FTICU_OP_S32 16'he688
`define FTICU_OP_U32 16'he68a
`define FTICU_OP_S16 16'he68c
`define FTICU_OP_U16 16'he68e
`define FTICU_MSW_ROUND_BIT 15
`define FTICU_MSW_DST_LSB 0
`define FTICU_MSW_SRC_LSB 3

// ----------------------------------------------------------------
// Conversion modes
// ----------------------------------------------------------------
`define FTICU_MODE_S16R 3'h0
`define FTICU_MODE_S32T 3'h1
`define FTICU_MODE_U16T 3'h2
`define FTICU_MODE_U16R 3'h3
`define FTICU_MODE_U32T 3'h4

// ----------------------------------------------------------------
// Float format
// ----------------------------------------------------------------
`define FTICU_EXP_TOP 8'h9e

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define FTICU_RESP_OKAY 2'h0
`define FTICU_RESP_SLVERR 2'h2

`endif

/* File: core/fticu_conv.v */
// Combinational single-precision to integer converter for all five modes
`timescale 1ns/1ps
`include "fticu_map.vh"

module fticu_conv (
	input wire [31:0] float_in,
	input wire [2:0] mode,
	output reg [31:0] int_out
);

	wire sign = float_in[31];
	wire [7:0] expo = float_in[30:23];
	// Denormals are below 2^-126 and always convert to zero, so they are dropped here
	wire [23:0] mant = (expo == 8'h00) ? 24'h000000 : {1'b1, float_in[22:0]};
	wire ovf = (expo > `FTICU_EXP_TOP);
	wire [7:0] rshift = `FTICU_EXP_TOP - expo;
	// Fixed point with 32 integer and 32 fraction bits; bits lost below only affect
	// values far under one half, which round to zero anyway
	wire [63:0] fixed = {mant, 40'h0000000000} >> rshift;
	wire [31:0] trunc = fixed[63:32];
	wire half = fixed[31];
	wire sticky = |fixed[30:0];
	wire round_up = half & (sticky | trunc[0]); // [RULE_05] [RULE_12]
	wire [32:0] rounded = {1'b0, trunc} + {32'h00000000, round_up};
	wire rnd_mode = (mode == `FTICU_MODE_S16R) || (mode == `FTICU_MODE_U16R);
	wire [32:0] mag = rnd_mode ? rounded : {1'b0, trunc};

	reg [15:0] s16;

	always @* begin
		s16 = 16'h0000;
		int_out = 32'h00000000;
		case (mode)
			`FTICU_MODE_S16R: begin
				if (sign) begin
					s16 = (ovf || mag > 33'h000008000) ? 16'h8000 : 16'h0000 - mag[15:0]; // [RULE_18]
				end else begin
					s16 = (ovf || mag > 33'h000007fff) ? 16'h7fff : mag[15:0]; // [RULE_18]
				end
				int_out = {{16{s16[15]}}, s16}; // [RULE_06]
			end
			`FTICU_MODE_S32T: begin
				if (sign) begin
					int_out = (ovf || mag > 33'h080000000) ? 32'h80000000 : 32'h00000000 - mag[31:0]; // [RULE_08] [RULE_18]
				end else begin
					int_out = (ovf || mag > 33'h07fffffff) ? 32'h7fffffff : mag[31:0]; // [RULE_08] [RULE_18]
				end
			end
			`FTICU_MODE_U16T, `FTICU_MODE_U16R: begin
				if (sign) begin
					int_out = 32'h00000000; // [RULE_14]
				end else if (ovf || mag > 33'h00000ffff) begin
					int_out = 32'h0000ffff; // [RULE_13]
				end else begin
					int_out = {16'h0000, mag[15:0]}; // [RULE_11] [RULE_12]
				end
			end
			`FTICU_MODE_U32T: begin
				if (sign) begin
					int_out = 32'h00000000; // [RULE_17]
				end else if (ovf) begin
					int_out = 32'hffffffff;
				end else begin
					int_out = trunc; // [RULE_16]
				end
			end
			default: begin
				int_out = 32'h00000000;
			end
		endcase
	end

endmodule // fticu_conv

/* File: core/fticu_top.v */
// Float-to-integer conversion unit: register file, issue pipeline and AXI4-Lite slave
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "fticu_map.vh"

module fticu_top #(
	parameter NUM_REGS = 8,
	parameter SEL_W = 3
) (
	input wire aclk,
	input wire aresetn,
	// Issue port from the host pipeline
	input wire issue_valid,
	input wire [15:0] issue_lsw,
	input wire [15:0] issue_msw,
	output wire issue_accept,
	// Writeback report towards the host pipeline
	output reg wb_valid,
	output reg [2:0] wb_dest,
	output reg [31:0] wb_data,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Decodes an opcode pair; bit 3 is the valid mark, bits 2:0 the mode
	function [3:0] decode_op;
		input [15:0] lsw;
		input [15:0] msw;
		reg upper_zero;
		reg rest_zero;
		begin
			upper_zero = (msw[15:6] == 10'h000);
			rest_zero = (msw[14:6] == 9'h000);
			decode_op = 4'h0;
			if (lsw == `FTICU_OP_S32 && upper_zero) begin
				decode_op = {1'b1, `FTICU_MODE_S32T}; // [RULE_07]
			end else if (lsw == `FTICU_OP_U32 && upper_zero) begin
				decode_op = {1'b1, `FTICU_MODE_U32T}; // [RULE_15]
			end else if (lsw == `FTICU_OP_U16 && rest_zero) begin
				if (msw[`FTICU_MSW_ROUND_BIT]) begin
					decode_op = {1'b1, `FTICU_MODE_U16R}; // [RULE_10]
				end else begin
					decode_op = {1'b1, `FTICU_MODE_U16T}; // [RULE_09]
				end
			end else if (lsw == `FTICU_OP_S16 && rest_zero && msw[`FTICU_MSW_ROUND_BIT]) begin
				decode_op = {1'b1, `FTICU_MODE_S16R};
			end
		end
	endfunction

	// Merges a write into a word under byte strobes
	function [31:0] merge_strb;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge_strb = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge_strb[i*8 +: 8] = data[i*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [31:0] freg [0:NUM_REGS-1];
	reg [`FTICU_STATUS_BITS-1:0] float_status_word;
	reg [31:0] last_opcode;
	reg [15:0] done_count;
	reg reject_seen;
	reg s1_valid;
	reg [2:0] s1_mode;
	reg [SEL_W-1:0] s1_dest;
	reg [31:0] s1_src;

	wire [31:0] conv_result;
	integer k;

	// ----------------------------------------------------------------
	// Issue arbitration
	// ----------------------------------------------------------------
	// The pipeline port has priority; a bus write to the issue register waits
	// for a cycle with no pipeline issue, which stalls its write response.
	wire [3:0] pipe_dec = decode_op(issue_lsw, issue_msw);
	assign issue_accept = issue_valid & pipe_dec[3];
	wire pipe_reject = issue_valid & ~pipe_dec[3];

	wire wr_both = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire wr_issue_reg = (s_axi_awaddr[7:2] == `FTICU_OFF_ISSUE >> 2);
	wire wr_go = wr_both & ~(wr_issue_reg & issue_valid);
	wire [3:0] bus_dec = decode_op(s_axi_wdata[15:0], s_axi_wdata[31:16]);
	wire bus_issue = wr_go & wr_issue_reg & bus_dec[3];
	wire bus_reject = wr_go & wr_issue_reg & ~bus_dec[3];

	wire any_issue = issue_accept | bus_issue; // [RULE_19]
	wire [15:0] sel_msw = issue_valid ? issue_msw : s_axi_wdata[31:16];
	wire [2:0] sel_mode = issue_valid ? pipe_dec[2:0] : bus_dec[2:0];
	wire [SEL_W-1:0] sel_src = sel_msw[`FTICU_MSW_SRC_LSB +: SEL_W]; // [RULE_04]
	wire [SEL_W-1:0] sel_dest = sel_msw[`FTICU_MSW_DST_LSB +: SEL_W]; // [RULE_04]

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;

	// ----------------------------------------------------------------
	// Converter
	// ----------------------------------------------------------------
	fticu_conv u_conv (
		.float_in(s1_src),
		.mode(s1_mode),
		.int_out(conv_result)
	);

	// ----------------------------------------------------------------
	// Pipeline: issue edge latches the operand, next edge writes back
	// ----------------------------------------------------------------
	// No forwarding: the delay-slot instruction may not touch the destination,
	// so the source is always read straight from the register file.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_valid <= 1'b0;
			s1_mode <= `FTICU_MODE_S16R;
			s1_dest <= {SEL_W{1'b0}};
			s1_src <= 32'h00000000;
			wb_valid <= 1'b0;
			wb_dest <= 3'h0;
			wb_data <= 32'h00000000;
			last_opcode <= 32'h00000000;
			done_count <= 16'h0000;
			reject_seen <= 1'b0;
		end else begin
			s1_valid <= any_issue; // [RULE_01] [RULE_19]
			if (any_issue) begin
				s1_mode <= sel_mode;
				s1_dest <= sel_dest;
				s1_src <= freg[sel_src]; // [RULE_02]
				last_opcode <= issue_valid ? {issue_msw, issue_lsw} : s_axi_wdata;
			end
			wb_valid <= s1_valid;
			if (s1_valid) begin
				wb_dest <= s1_dest;
				wb_data <= conv_result;
				done_count <= done_count + 16'h0001;
			end
			if (pipe_reject | bus_reject) begin
				reject_seen <= 1'b1;
			end else if (wr_go && s_axi_awaddr[7:2] == `FTICU_OFF_INFO >> 2 && s_axi_wstrb[2]
					&& s_axi_wdata[`FTICU_INFO_REJECT_BIT]) begin
				reject_seen <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Float register file and status word
	// ----------------------------------------------------------------
	wire wr_freg = wr_go & (s_axi_awaddr[7:5] == 3'h0);
	wire [SEL_W-1:0] wr_idx = s_axi_awaddr[4:2];

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (k = 0; k < NUM_REGS; k = k + 1) begin
				freg[k] <= 32'h00000000;
			end
			float_status_word <= `FTICU_STATUS_RESET;
		end else begin
			// A bus write to the register being written back loses to the result
			if (wr_freg && !(s1_valid && s1_dest == wr_idx)) begin
				freg[wr_idx] <= merge_strb(freg[wr_idx], s_axi_wdata, s_axi_wstrb);
			end
			if (s1_valid) begin
				freg[s1_dest] <= conv_result; // [RULE_01]
			end
			// Only software touches the flags; no conversion path reaches them
			if (wr_go && s_axi_awaddr[7:2] == `FTICU_OFF_STATUS >> 2 && s_axi_wstrb[0]) begin
				float_status_word <= s_axi_wdata[`FTICU_STATUS_BITS-1:0]; // [RULE_03]
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write response
	// ----------------------------------------------------------------
	wire wr_mapped = (s_axi_awaddr[7:5] == 3'h0) || (s_axi_awaddr[7:2] == `FTICU_OFF_STATUS >> 2)
		|| wr_issue_reg || (s_axi_awaddr[7:2] == `FTICU_OFF_INFO >> 2);
	wire wr_ok = wr_mapped & ~bus_reject & (s_axi_awaddr[1:0] == 2'h0);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FTICU_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `FTICU_RESP_OKAY : `FTICU_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

	reg [31:0] rd_word;
	reg rd_hit;

	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		if (s_axi_araddr[7:5] == 3'h0) begin
			rd_word = freg[s_axi_araddr[4:2]];
		end else if (s_axi_araddr[7:2] == `FTICU_OFF_STATUS >> 2) begin
			rd_word = {25'h0000000, float_status_word};
		end else if (s_axi_araddr[7:2] == `FTICU_OFF_ISSUE >> 2) begin
			rd_word = last_opcode;
		end else if (s_axi_araddr[7:2] == `FTICU_OFF_INFO >> 2) begin
			rd_word = {14'h0000, s1_valid, reject_seen, done_count};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FTICU_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `FTICU_RESP_OKAY : `FTICU_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // fticu_top

/* File: bench/fticu_chk.sv */
// Concurrent checks on the issue, writeback and write-answer ports of the conversion unit
`timescale 1ns/1ps
`include "fticu_map.vh"
module fticu_chk (
	input wire aclk,
	input wire aresetn,
	input wire issue_valid,
	input wire [15:0] issue_lsw,
	input wire [15:0] issue_msw,
	input wire issue_accept,
	input wire wb_valid,
	input wire [2:0] wb_dest,
	input wire [31:0] wb_data,
	input wire s_axi_bvalid,
	input wire s_axi_bready
);
	wire [2:0] msw_dst = issue_msw[2:0];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_s32_decode: assert property (
		issue_valid && issue_lsw == `FTICU_OP_S32 && issue_msw[15:6] == 10'h000 |-> issue_accept)
		else $error("signed 32-bit opcode refused");
	chk_u32_decode: assert property (
		issue_valid && issue_lsw == `FTICU_OP_U32 && issue_msw[15:6] == 10'h000 |-> issue_accept)
		else $error("unsigned 32-bit opcode refused");
	chk_u16_decode: assert property (
		issue_valid && issue_lsw == `FTICU_OP_U16 && issue_msw[14:6] == 9'h000 |-> issue_accept)
		else $error("unsigned 16-bit opcode refused");
	chk_wb_latency: assert property (
		issue_accept |-> ##2 wb_valid)
		else $error("writeback not two cycles after issue");
	chk_wb_dest: assert property (
		issue_accept |-> ##2 (wb_dest == $past(msw_dst, 2)))
		else $error("writeback to wrong register");
	chk_u16_upper: assert property (
		wb_valid && $past(issue_accept, 2) && $past(issue_lsw, 2) == `FTICU_OP_U16
		|-> wb_data[31:16] == 16'h0000)
		else $error("unsigned 16-bit upper half not clear");
	chk_s16_extend: assert property (
		wb_valid && $past(issue_accept, 2) && $past(issue_lsw, 2) == `FTICU_OP_S16
		|-> wb_data[31:16] == {16{wb_data[15]}})
		else $error("signed 16-bit upper half not sign copies");
	chk_bvalid_once: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule // fticu_chk

/* File: bench/fticu_host.sv */
// Host pipeline model: issues queued conversions, one a cycle, keeping the delay slot clear
`timescale 1ns/1ps
module fticu_host (
	input wire aclk,
	input wire aresetn,
	input wire slow,
	output reg issue_valid = 1'b0,
	output reg [15:0] issue_lsw = 16'h0000,
	output reg [15:0] issue_msw = 16'h0000
);
	logic [31:0] q[$];
	task push(input [15:0] lsw, input [15:0] msw);
		q.push_back({msw, lsw});
	endtask
	// A slot that reuses the previous destination gets a bubble; idle words toggle as junk
	always @(posedge aclk) begin
		if (!aresetn || q.size() == 0 || (slow && $urandom % 3 == 0) || (issue_valid
			&& (q[0][21:19] == issue_msw[2:0] || q[0][18:16] == issue_msw[2:0]))) begin
			issue_valid <= 1'b0;
			issue_lsw <= ~issue_lsw;
			issue_msw <= ~issue_msw;
		end else begin
			issue_valid <= 1'b1;
			{issue_msw, issue_lsw} <= q.pop_front();
		end
	end
endmodule // fticu_host

/* File: bench/fticu_top_tb.sv */
// Self-checking bench for the conversion unit: corner and random conversions, register bus
`timescale 1ns/1ps
`include "fticu_map.vh"
module fticu_top_tb;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg slow = 1'b0;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg [31:0] wdata = 32'h0, rd, v;
	reg [1:0] rs;
	wire issue_valid, issue_accept, wb_valid, awready, wready, bvalid, arready, rvalid;
	wire [15:0] issue_lsw, issue_msw;
	wire [2:0] wb_dest;
	wire [31:0] wb_data, rdata;
	wire [1:0] bresp, rresp;
	reg [31:0] fm [0:7] = '{8{32'h0}};
	reg [31:0] cf [0:15] = '{32'h3fd9999a, 32'hbfd9999a, 32'h40200000, 32'h40600000,
		32'h4b2af5a5, 32'hcb2af5a5, 32'hcf800000, 32'h41100000, 32'hc1100000, 32'h48927c00,
		32'h412ccccd, 32'hc12ccccd, 32'h48927c00, 32'h41480000, 32'hc0d00000, 32'h4f800000};
	reg [2:0] cm [0:15] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 4, 4, 4};
	reg [34:0] exq[$];
	integer error_cnt = 0, check_count = 0, cyc = 0, n_conv = 0, i, k;
	always #25 aclk = ~aclk;
	fticu_top uut (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
		.issue_lsw(issue_lsw), .issue_msw(issue_msw), .issue_accept(issue_accept),
		.wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fticu_host u_host (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.issue_valid(issue_valid), .issue_lsw(issue_lsw), .issue_msw(issue_msw));
	task check(input [63:0] seen, input [63:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic [2:0] dec(input [15:0] l, input [15:0] m);
		dec = l == `FTICU_OP_S32 ? `FTICU_MODE_S32T : l == `FTICU_OP_U32 ? `FTICU_MODE_U32T :
			l == `FTICU_OP_S16 ? `FTICU_MODE_S16R : m[15] ? `FTICU_MODE_U16R : `FTICU_MODE_U16T;
	endfunction
	// Magnitude in 32.32 fixed point; anything past the top exponent saturates by sign
	function automatic [31:0] ref_conv(input [31:0] f, input [2:0] md);
		reg [63:0] fx;
		reg [32:0] m;
		begin
			fx = f[30:23] == 8'h00 ? 64'h0 : {1'b1, f[22:0], 40'h0} >> (158 - f[30:23]);
			m = {1'b0, fx[63:32]} + ((md == `FTICU_MODE_S16R || md == `FTICU_MODE_U16R)
				&& (fx[31:0] > 32'h80000000 || (fx[31:0] == 32'h80000000 && fx[32])));
			if (f[30:23] > `FTICU_EXP_TOP)
				m = 33'h1ffffffff;
			case (md)
			`FTICU_MODE_S16R: ref_conv = f[31] ? (m > 33'h8000 ? 32'hffff8000 : 32'h0 - m[31:0])
				: (m > 33'h7fff ? 32'h7fff : m[31:0]);
			`FTICU_MODE_S32T: ref_conv = f[31] ? (m > 33'h80000000 ? 32'h80000000 : 32'h0 - m[31:0])
				: (m > 33'h7fffffff ? 32'h7fffffff : m[31:0]);
			`FTICU_MODE_U32T: ref_conv = f[31] ? 32'h0 : (m[32] ? 32'hffffffff : m[31:0]);
			default: ref_conv = f[31] ? 32'h0 : (m > 33'hffff ? 32'hffff : m[31:0]);
			endcase
		end
	endfunction
	// Waits have no local limit: only the cycle ceiling below ends a hung transfer
	task axi_wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (awvalid && awready)
					awvalid <= 1'b0;
				if (wvalid && wready)
					wvalid <= 1'b0;
			end while (!bvalid);
			rs = bresp;
			bready <= 1'b0;
		end
	endtask
	task axi_rd(input [7:0] a);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (arvalid && arready)
					arvalid <= 1'b0;
			end while (!rvalid);
			rd = rdata;
			rs = rresp;
			rready <= 1'b0;
		end
	endtask
	task setreg(input [2:0] r, input [31:0] val);
		axi_wr({3'h0, r, 2'h0}, val);
		fm[r] = val;
		check(rs, `FTICU_RESP_OKAY);
	endtask
	task conv(input [2:0] md, input [2:0] s, input [2:0] dd);
		n_conv = n_conv + 1;
		u_host.push(md == `FTICU_MODE_S16R ? `FTICU_OP_S16 : md == `FTICU_MODE_S32T ? `FTICU_OP_S32
			: md == `FTICU_MODE_U32T ? `FTICU_OP_U32 : `FTICU_OP_U16,
			{md == `FTICU_MODE_S16R || md == `FTICU_MODE_U16R, 9'h000, s, dd});
	endtask
	task drain;
		while (u_host.q.size() != 0)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (wb_valid && exq.size() == 0)
			check(1, 0);
		else if (wb_valid) begin
			check({wb_dest, wb_data}, exq[0]);
			fm[exq[0][34:32]] = exq[0][31:0];
			void'(exq.pop_front());
		end
		if (issue_accept)
			exq.push_back({issue_msw[2:0], ref_conv(fm[issue_msw[5:3]], dec(issue_lsw, issue_msw))});
		if (cyc > 20000) begin
			error_cnt = error_cnt + 1;
			print_verdict;
		end
	end
	initial begin
		i = $urandom(86);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h04);
		check(rd, 32'h0);
		axi_rd(`FTICU_OFF_STATUS);
		check(rd, 32'h0);
		axi_wr(`FTICU_OFF_STATUS, 32'h7f);
		for (i = 0; i < 16; i = i + 1) begin
			setreg(i % 4, cf[i]);
			conv(cm[i], i % 4, 4 + i % 4);
			drain;
		end
		for (k = 0; k < 2; k = k + 1) begin
			slow <= k[0];
			for (i = 0; i < 8; i = i + 1) begin
				v = {1'($urandom), 8'(112 + $urandom % 50), 23'($urandom)};
				if ($urandom % 3 == 0)
					v[12:0] = 13'h0;
				setreg(i, v);
			end
			for (i = 0; i < 100; i = i + 1)
				conv(3'($urandom % 5), 3'($urandom), 3'($urandom));
			drain;
			for (i = 0; i < 8; i = i + 1) begin
				axi_rd(8'(i * 4));
				check(rd, fm[i]);
			end
		end
		u_host.push(`FTICU_OP_S16, 16'h0009);
		u_host.push(`FTICU_OP_S32, 16'h0400);
		drain;
		axi_rd(`FTICU_OFF_INFO);
		check(rd, {14'h0000, 2'b01, n_conv[15:0]});
		axi_wr(`FTICU_OFF_INFO, 32'h00010000);
		axi_rd(`FTICU_OFF_INFO);
		check(rd[`FTICU_INFO_REJECT_BIT], 1'b0);
		// Bus-issued conversion: signed 32-bit from register 1 into register 2
		exq.push_back({3'h2, ref_conv(fm[1], `FTICU_MODE_S32T)});
		axi_wr(`FTICU_OFF_ISSUE, {16'h000a, `FTICU_OP_S32});
		check(rs, `FTICU_RESP_OKAY);
		drain;
		axi_wr(`FTICU_OFF_ISSUE, {16'h0000, `FTICU_OP_S16});
		check(rs, `FTICU_RESP_SLVERR);
		axi_rd(`FTICU_OFF_ISSUE);
		check(rd, {16'h000a, `FTICU_OP_S32});
		axi_rd(8'h08);
		check(rd, fm[2]);
		axi_rd(`FTICU_OFF_STATUS);
		check(rd, 32'h7f);
		axi_rd(8'h40);
		check(rs, `FTICU_RESP_SLVERR);
		check(exq.size(), 0);
		print_verdict;
	end
endmodule // fticu_top_tb
bind fticu_top fticu_chk u_chk (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
	.issue_lsw(issue_lsw), .issue_msw(issue_msw), .issue_accept(issue_accept),
	.wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
